// ---- design/uie_pkg.sv ----
// Shared constants, types and decode helpers for the UART interrupt and status block.
// Assumes one 40 MHz clock and a host on an eight-bit register port with three address lines.
package uie_pkg;

  // ****************************************
  // Widths and register addresses
  // ****************************************
  localparam int CNT_W = 6;
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_MASK = 3'h1;
  localparam logic [2:0] A_SRC = 3'h2;
  localparam logic [2:0] A_LCTL = 3'h3;
  localparam logic [2:0] A_MCTL = 3'h4;
  localparam logic [2:0] A_LSTAT = 3'h5;
  localparam logic [2:0] A_MSTAT = 3'h6;
  localparam logic [2:0] A_SCRATCH = 3'h7;
  localparam logic [2:0] A_REV = 3'h0;
  localparam logic [2:0] A_PID = 3'h1;
  localparam logic [2:0] A_DIVLO = 3'h0;
  localparam logic [2:0] A_DIVHI = 3'h1;
  localparam logic [2:0] A_DIVFR = 3'h2;
  localparam logic [2:0] A_EFC = 3'h2;
  localparam logic [2:0] A_RES1 = 3'h4;
  localparam logic [2:0] A_RES2 = 3'h5;
  localparam logic [2:0] A_STOP1 = 3'h6;
  localparam logic [2:0] A_STOP2 = 3'h7;

  // ****************************************
  // Field positions, keys and reset values
  // ****************************************
  localparam logic [7:0] ENH_KEY = 8'hbf;
  localparam int LCR_DIV_BIT = 7;
  localparam int EFC_ENH_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;

  // ****************************************
  // Interrupt source codes and receive triggers
  // ****************************************
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RXTO = 6'h0c;
  localparam logic [5:0] CODE_RXDA = 6'h04;
  localparam logic [5:0] CODE_TXRDY = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam logic [CNT_W-1:0] RX_TRIG_0 = 6'h08;
  localparam logic [CNT_W-1:0] RX_TRIG_1 = 6'h10;
  localparam logic [CNT_W-1:0] RX_TRIG_2 = 6'h18;
  localparam logic [CNT_W-1:0] RX_TRIG_3 = 6'h1c;

  // Sources listed from highest priority down
  typedef enum logic [2:0] {SRC_LINE, SRC_RXTO, SRC_RXDA, SRC_TXRDY, SRC_MODEM, SRC_XOFF, SRC_FLOW,
                            SRC_NONE} uie_src_e;

  // Receive side status from the FIFO core
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [2:0] head_err;
    logic fifo_err;
  } uie_rx_s;

  // Host-programmed configuration
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] fctl;
    logic [7:0] lctl;
    logic [7:0] mctl;
    logic [7:0] efc;
    logic [7:0] divlo;
    logic [7:0] divhi;
    logic [7:0] divfr;
    logic [7:0] altf;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] stop1;
    logic [7:0] stop2;
  } uie_cfg_s;

  function automatic logic [5:0] uie_code(input uie_src_e s);
    case (s)
      SRC_LINE: uie_code = CODE_LINE;
      SRC_RXTO: uie_code = CODE_RXTO;
      SRC_RXDA: uie_code = CODE_RXDA;
      SRC_TXRDY: uie_code = CODE_TXRDY;
      SRC_MODEM: uie_code = CODE_MODEM;
      SRC_XOFF: uie_code = CODE_XOFF;
      SRC_FLOW: uie_code = CODE_FLOW;
      default: uie_code = CODE_NONE;
    endcase
  endfunction : uie_code

  function automatic logic [CNT_W-1:0] uie_rx_trig(input logic [1:0] sel);
    case (sel)
      2'h0: uie_rx_trig = RX_TRIG_0;
      2'h1: uie_rx_trig = RX_TRIG_1;
      2'h2: uie_rx_trig = RX_TRIG_2;
      default: uie_rx_trig = RX_TRIG_3;
    endcase
  endfunction : uie_rx_trig

endpackage : uie_pkg

// ---- design/uie_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the level is slow against the 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module uie_sync
  import uie_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : uie_sync
`default_nettype wire

// ---- design/uie_prio.sv ----
// Fixed-priority picker over the pending interrupt sources.
// Assumes bit 0 of the pending vector is the highest priority source.
`timescale 1ns/100ps
`default_nettype none
module uie_prio
  import uie_pkg::*;
(
  input wire logic [6:0] pend_i,
  output uie_src_e top_o
);

  // Scan from lowest priority up so the highest pending wins last
  always_comb
  begin
    top_o = SRC_NONE;
    for (int i = 6; i >= 0; i--)
    begin
      if (pend_i[i])
      begin
        top_o = uie_src_e'(i[2:0]);
      end
    end
  end

endmodule : uie_prio
`default_nettype wire

// ---- design/uie_core.sv ----
// Interrupt mask, interrupt source, line status and enhanced register gating for one UART channel.
// Assumes the FIFO core, flow engines and modem logic run on clk_i and report status here.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Enhanced mask, source, fifo, modem and fraction fields locked unless enhanced bit 4 set.
// - Receive data interrupt raised once receive FIFO reaches programmed trigger level.
// - Receive level source and interrupt clear when count drops below trigger.
// - Data ready flag set on character arrival, cleared when FIFO empty.
// - FIFOs on with mask bits 0-3 clear gives polled mode via line status.
// - Line status bit 1 flags receive overrun.
// - Line status bits 2-4 show errors of the byte at the receive head.
// - Bit 5 shows holding register empty; bit 6 shows FIFO and shifter empty.
// - Bit 7 set while any FIFO character carries a data error.
// - Mask bit 0 enables receive data interrupt, per FIFO or non-FIFO mode.
// - Mask bit 1 enables transmit ready; enabling while empty interrupts at once.
// - Mask bit 2 enables line interrupt; overrun immediate, other errors at readout.
// - Mask bit 3 gates the modem status interrupt.
// - Mask bit 4 enables sleep; writable only with enhanced bit 4 set.
// - Mask bit 5 enables stop character interrupt; enhanced access only.
// - Mask bit 6 interrupts on RTS output rising from low to high.
// - Mask bit 7 interrupts on CTS input rising from low to high.
// - All mask bits reset to zero.
// - Source register reads give the held or else highest pending code in bits 0-5.
// - No other interrupt acknowledged until the reported one is serviced.
// - Source bit 0 reads zero when pending, one when idle and after reset.
// - Priority runs line, timeout, receive, transmit, modem, stop char, flow pin.
module uie_core
  import uie_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01,
  parameter logic [7:0] PART_ID = 8'h5a
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire uie_rx_s rx_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_overrun_i,
  input wire logic rx_timeout_i,
  input wire logic tx_hold_empty_i,
  input wire logic tx_all_empty_i,
  input wire logic tx_below_trig_i,
  input wire logic [7:0] modem_stat_i,
  input wire logic stop_match_i,
  input wire logic resume_match_i,
  input wire logic rts_n_i,
  input wire logic cts_n_pin_i,
  output uie_cfg_s cfg_o,
  output logic rx_pop_o,
  output logic tx_push_o,
  output logic modem_rd_o,
  output logic rx_fifo_clr_o,
  output logic tx_fifo_clr_o,
  output logic irq_o
);

  // ****************************************
  // Access decode
  // ****************************************
  uie_cfg_s cfg_ff;
  logic [7:0] scratch_ff;
  logic [7:0] rdata_ff;
  logic enh;
  logic dlab;
  logic efr4;
  logic fifo_en;
  logic std_lo;
  logic div_lo;
  logic norm_hi;
  logic id_ok;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] b);
    hit = (a == b);
  endfunction : hit

  assign enh = (cfg_ff.lctl == ENH_KEY);
  assign dlab = cfg_ff.lctl[LCR_DIV_BIT];
  assign efr4 = cfg_ff.efc[EFC_ENH_BIT];
  assign fifo_en = cfg_ff.fctl[FCR_EN_BIT];
  assign std_lo = !dlab;
  assign div_lo = dlab && !enh;
  assign norm_hi = !enh;
  assign id_ok = div_lo && (cfg_ff.divlo == DIV_RST) && (cfg_ff.divhi == DIV_RST);

  // Strobes that act on the core beside storing values
  assign rx_pop_o = rd_i && std_lo && hit(addr_i, A_DATA);
  assign tx_push_o = wr_i && std_lo && hit(addr_i, A_DATA);
  assign modem_rd_o = rd_i && norm_hi && hit(addr_i, A_MSTAT);
  // Reset bits act only with the enable bit in the same write
  assign rx_fifo_clr_o = wr_i && std_lo && hit(addr_i, A_SRC) && wdata_i[FCR_EN_BIT] && wdata_i[FCR_RXRST_BIT];
  assign tx_fifo_clr_o = wr_i && std_lo && hit(addr_i, A_SRC) && wdata_i[FCR_EN_BIT] && wdata_i[FCR_TXRST_BIT];

  logic rd_src;
  logic rd_lsr;
  logic wr_mask;
  assign rd_src = rd_i && std_lo && hit(addr_i, A_SRC);
  assign rd_lsr = rd_i && norm_hi && hit(addr_i, A_LSTAT);
  assign wr_mask = wr_i && std_lo && hit(addr_i, A_MASK);

  // ****************************************
  // Host configuration registers
  // ****************************************
  // Enhanced fields keep their value when the unlock bit is clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cfg_ff <= '0;
      scratch_ff <= REG_RST;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, A_LCTL))
      begin
        cfg_ff.lctl <= wdata_i;
      end
      if (wr_mask)
      begin
        cfg_ff.mask <= {efr4 ? wdata_i[7:4] : cfg_ff.mask[7:4], wdata_i[3:0]};
      end
      if (std_lo && hit(addr_i, A_SRC))
      begin
        if (wdata_i[FCR_EN_BIT])
        begin
          cfg_ff.fctl <= {wdata_i[7:6], efr4 ? wdata_i[5:4] : cfg_ff.fctl[5:4], wdata_i[3], 3'h1};
        end
        else
        begin
          cfg_ff.fctl <= {cfg_ff.fctl[7:1], 1'b0};
        end
      end
      if (div_lo && hit(addr_i, A_DIVLO))
      begin
        cfg_ff.divlo <= wdata_i;
      end
      if (div_lo && hit(addr_i, A_DIVHI))
      begin
        cfg_ff.divhi <= wdata_i;
      end
      if (div_lo && hit(addr_i, A_DIVFR))
      begin
        if (efr4)
        begin
          cfg_ff.divfr <= {2'h0, wdata_i[5:0]};
        end
        else
        begin
          cfg_ff.altf <= {5'h00, wdata_i[2:0]};
        end
      end
      if (enh && hit(addr_i, A_EFC))
      begin
        cfg_ff.efc <= wdata_i;
      end
      if (norm_hi && hit(addr_i, A_MCTL))
      begin
        cfg_ff.mctl <= {efr4 ? wdata_i[7:5] : cfg_ff.mctl[7:5], wdata_i[4:0]};
      end
      if (norm_hi && hit(addr_i, A_SCRATCH))
      begin
        scratch_ff <= wdata_i;
      end
      // Flow match characters only under the access code
      if (enh && hit(addr_i, A_RES1))
      begin
        cfg_ff.res1 <= wdata_i;
      end
      if (enh && hit(addr_i, A_RES2))
      begin
        cfg_ff.res2 <= wdata_i;
      end
      if (enh && hit(addr_i, A_STOP1))
      begin
        cfg_ff.stop1 <= wdata_i;
      end
      if (enh && hit(addr_i, A_STOP2))
      begin
        cfg_ff.stop2 <= wdata_i;
      end
    end
  end

  assign cfg_o = cfg_ff;

  // ****************************************
  // Pin and edge capture
  // ****************************************
  logic cts_n_s;
  logic cts_q_ff;
  logic rts_q_ff;
  logic txc_q_ff;
  logic err_seen_ff;

  uie_sync #(.RST_VAL(1'b1)) u_cts_sync
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(cts_n_pin_i),
    .sync_o(cts_n_s)
  );

  logic dr;
  logic head_bad;
  logic txc;
  assign dr = (rx_i.count != '0);
  assign head_bad = dr && (|rx_i.head_err);
  // Non-FIFO mode watches the holding register, FIFO mode the trigger
  assign txc = fifo_en ? tx_below_trig_i : tx_hold_empty_i;

  // Previous values for edge detection
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cts_q_ff <= 1'b1;
      rts_q_ff <= 1'b1;
      txc_q_ff <= 1'b1;
      err_seen_ff <= 1'b0;
    end
    else
    begin
      cts_q_ff <= cts_n_s;
      rts_q_ff <= rts_n_i;
      txc_q_ff <= txc;
      err_seen_ff <= head_bad;
    end
  end

  // ****************************************
  // Sticky interrupt causes; set wins over clear
  // ****************************************
  uie_src_e rep;
  uie_src_e cur_ff;
  logic ovr_ff;
  logic line_ff;
  logic rxto_ff;
  logic tx_ff;
  logic stop_ff;
  logic flow_ff;
  logic set_line;
  logic set_tx;
  logic set_flow;

  // Errors of the head byte interrupt once it reaches the read port
  assign set_line = rx_overrun_i || (head_bad && !err_seen_ff);
  assign set_tx = (txc && !txc_q_ff) || (wr_mask && wdata_i[1] && !cfg_ff.mask[1] && tx_hold_empty_i);
  assign set_flow = (cfg_ff.mask[6] && rts_n_i && !rts_q_ff)
                 || (cfg_ff.mask[7] && cts_n_s && !cts_q_ff);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ovr_ff <= 1'b0;
      line_ff <= 1'b0;
    end
    else
    begin
      ovr_ff <= rx_overrun_i || (ovr_ff && !rd_lsr);
      line_ff <= set_line || (line_ff && !rd_lsr);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rxto_ff <= 1'b0;
      tx_ff <= 1'b0;
    end
    else
    begin
      rxto_ff <= rx_timeout_i || (rxto_ff && !rx_pop_o);
      tx_ff <= set_tx || (tx_ff && !tx_push_o && !(rd_src && rep == SRC_TXRDY));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stop_ff <= 1'b0;
      flow_ff <= 1'b0;
    end
    else
    begin
      stop_ff <= stop_match_i || (stop_ff && !rd_src && !resume_match_i);
      flow_ff <= set_flow || (flow_ff && !modem_rd_o);
    end
  end

  // ****************************************
  // Pending sources and reporting
  // ****************************************
  logic [7:0] pend;
  logic at_trig;
  uie_src_e top;
  assign at_trig = (rx_i.count >= uie_rx_trig(cfg_ff.fctl[7:6]));
  // With mask bits 0-3 clear only stop char and flow pin sources can fire; host polls line status
  assign pend[0] = cfg_ff.mask[2] && line_ff;
  assign pend[1] = cfg_ff.mask[0] && fifo_en && rxto_ff;
  assign pend[2] = cfg_ff.mask[0] && (fifo_en ? at_trig : dr);
  assign pend[3] = cfg_ff.mask[1] && tx_ff;
  assign pend[4] = cfg_ff.mask[3] && (|modem_stat_i[3:0]);
  assign pend[5] = efr4 && cfg_ff.mask[5] && stop_ff;
  assign pend[6] = efr4 && flow_ff;
  assign pend[7] = 1'b0;

  uie_prio u_prio
  (
    .pend_i(pend[6:0]),
    .top_o(top)
  );

  // Reported source holds while still pending so others wait
  assign rep = (cur_ff != SRC_NONE && pend[cur_ff]) ? cur_ff : top;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cur_ff <= SRC_NONE;
    end
    else
    begin
      cur_ff <= rep;
    end
  end

  assign irq_o = (rep != SRC_NONE);

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rd_val;
  logic [7:0] lsr_val;
  logic [5:0] code;
  assign code = uie_code(rep);
  assign lsr_val = {rx_i.fifo_err, tx_all_empty_i, tx_hold_empty_i, rx_i.head_err, ovr_ff, dr};

  always_comb
  begin
    rd_val = 8'h00;
    if (hit(addr_i, A_LCTL))
    begin
      rd_val = cfg_ff.lctl;
    end
    else if (enh && hit(addr_i, A_EFC))
    begin
      rd_val = cfg_ff.efc;
    end
    else if (enh)
    begin
      case (addr_i)
        A_RES1: rd_val = cfg_ff.res1;
        A_RES2: rd_val = cfg_ff.res2;
        A_STOP1: rd_val = cfg_ff.stop1;
        A_STOP2: rd_val = cfg_ff.stop2;
        default: rd_val = 8'h00;
      endcase
    end
    else
    begin
      case (addr_i)
        A_DATA: rd_val = dlab ? (id_ok ? REVISION : cfg_ff.divlo) : rx_data_i;
        A_MASK: rd_val = dlab ? (id_ok ? PART_ID : cfg_ff.divhi)
                              : {efr4 ? cfg_ff.mask[7:4] : 4'h0, cfg_ff.mask[3:0]};
        A_SRC: rd_val = dlab ? (efr4 ? cfg_ff.divfr : cfg_ff.altf)
                             : {{2{fifo_en}}, efr4 ? code[5:4] : 2'h0, code[3:0]};
        A_MCTL: rd_val = {efr4 ? cfg_ff.mctl[7:5] : 3'h0, cfg_ff.mctl[4:0]};
        A_LSTAT: rd_val = lsr_val;
        A_MSTAT: rd_val = modem_stat_i;
        A_SCRATCH: rd_val = scratch_ff;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // Read data stands until the next read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_ff <= 8'h00;
    end
    else if (rd_i)
    begin
      rdata_ff <= rd_val;
    end
  end

  assign rdata_o = rdata_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_src_read_idle;
    rd_src && rep == SRC_NONE;
  endsequence

  sequence s_lsr_read_ready;
    rd_lsr && dr;
  endsequence

  sequence s_mask_enable_tx;
    wr_mask && wdata_i[1] && !cfg_ff.mask[1] && tx_hold_empty_i;
  endsequence

  AST_MASK_RESET: assert property ($past(reset_i) |-> cfg_ff.mask == 8'h00 && cur_ff == SRC_NONE)
    else $error("mask not cleared by reset");
  AST_ENH_LOCK: assert property (wr_mask && !efr4 |=> cfg_ff.mask[7:4] == $past(cfg_ff.mask[7:4]))
    else $error("enhanced mask bits written while locked");
  AST_RX_LEVEL: assert property (rep == SRC_RXDA && fifo_en |-> at_trig && irq_o)
    else $error("receive level reported below trigger");
  AST_RX_RAISE: assert property (fifo_en && cfg_ff.mask[0] && at_trig |-> irq_o)
    else $error("receive trigger reached without interrupt");
  AST_IDLE_CODE: assert property (s_src_read_idle |-> !irq_o ##1 rdata_o[0])
    else $error("idle source read not one");
  AST_DATA_READY: assert property (s_lsr_read_ready |=> rdata_o[0])
    else $error("data ready flag missing");
  AST_OVERRUN: assert property (rx_overrun_i |=> ovr_ff && line_ff)
    else $error("overrun not flagged");
  // Overrun flag stays up until the host reads line status
  AST_OVR_HOLD: assert property (ovr_ff && !rd_lsr |=> ovr_ff)
    else $error("overrun flag dropped before status read");
  AST_TX_NOW: assert property (s_mask_enable_tx |=> tx_ff && irq_o)
    else $error("transmit ready not raised on enable");
  AST_CTS_RISE: assert property (cfg_ff.mask[7] && cts_n_s && !cts_q_ff |=> flow_ff)
    else $error("cts rise not caught");
  AST_HOLD_SRC: assert property (cur_ff != SRC_NONE && pend[cur_ff] |-> rep == cur_ff)
    else $error("reported source changed while pending");

endmodule : uie_core
`default_nettype wire

// ---- tb/uie_line_model.sv ----
// Behavioural stand-in for the receive FIFO core that feeds the status block.
// Assumes pop_i comes from the block's data-read strobe on the same clock.
`timescale 1ns/100ps
`default_nettype none
module uie_line_model
  import uie_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic add_i,
  input wire logic [2:0] err_i,
  input wire logic pop_i,
  output var uie_rx_s rx_o,
  output var logic [7:0] data_o
);
  // ********
  // Receive queue
  // ********
  logic [2:0] errq[$];
  logic fe;

  // Queue of per-character error flags; outputs follow one edge later like a real core
  always @(posedge clk_i)
  begin
    if (reset_i)
      errq.delete();
    else
    begin
      if (pop_i && errq.size() > 0)
        void'(errq.pop_front());
      if (add_i)
        errq.push_back(err_i);
    end
    fe = 1'b0;
    foreach (errq[i])
      if (errq[i] != 3'h0)
        fe = 1'b1;
    rx_o.count <= CNT_W'(errq.size());
    rx_o.head_err <= (errq.size() > 0) ? errq[0] : 3'h0;
    rx_o.fifo_err <= fe;
    // Data byte changes with the level, so a stale head never looks valid
    data_o <= {2'b10, CNT_W'(errq.size())};
  end
endmodule : uie_line_model
`default_nettype wire

// ---- tb/uie_core_tb_top.sv ----
// Self-checking bench for the interrupt and status block, driven through its register port.
// Assumes the line model supplies receive status and the bench drives all other status.
`timescale 1ns/100ps
`default_nettype none
module uie_core_tb_top import uie_pkg::*;;
  // ********
  // Signals and instances
  // ********
  localparam logic [7:0] REV_V = 8'h3c; // Arbitrary value
  localparam logic [7:0] PID_V = 8'h9d; // Arbitrary value
  // FIFO control is written at the address that reads back the source
  localparam logic [2:0] A_FCTL = A_SRC;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [2:0] err = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] modem_stat_i = 8'h00;
  logic [7:0] rdata_o, rx_data_i;
  logic rd_i = 1'b0, wr_i = 1'b0, add = 1'b0, ovr = 1'b0, tmo = 1'b0;
  logic hold = 1'b1, alle = 1'b1, below = 1'b1, stp = 1'b0, res = 1'b0;
  logic rts_n_i = 1'b1, cts_n_pin_i = 1'b1, irq_o, rx_pop_o;
  uie_rx_s rx_i;
  uie_cfg_s cfg;
  int num_errors = 0;
  int samples_checked = 0;

  // Clock at 40 MHz
  always #12.5 clk_i = ~clk_i;

  uie_core #(.REVISION(REV_V), .PART_ID(PID_V)) u_uie_core (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rx_i(rx_i),
    .rx_data_i(rx_data_i), .rx_overrun_i(ovr), .rx_timeout_i(tmo), .tx_hold_empty_i(hold),
    .tx_all_empty_i(alle), .tx_below_trig_i(below), .modem_stat_i(modem_stat_i),
    .stop_match_i(stp), .resume_match_i(res), .rts_n_i(rts_n_i), .cts_n_pin_i(cts_n_pin_i),
    .cfg_o(cfg), .rx_pop_o(rx_pop_o), .tx_push_o(), .modem_rd_o(), .rx_fifo_clr_o(),
    .tx_fifo_clr_o(), .irq_o(irq_o));

  uie_line_model u_uie_line_model (.clk_i(clk_i), .reset_i(reset_i), .add_i(add), .err_i(err),
    .pop_i(rx_pop_o), .rx_o(rx_i), .data_o(rx_data_i));

  // ********
  // Port tasks
  // ********
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobe drops for a cycle so two writes never share a time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    tick;
    wr_i = 1'b0;
    tick;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    addr_i = a;
    rd_i = 1'b1;
    tick;
    rd_i = 1'b0;
    tick;
    chk(rdata_o, e);
  endtask : rd

  task automatic push(input logic [2:0] e, input int n);
    err = e;
    add = 1'b1;
    repeat (n) tick;
    add = 1'b0;
    tick;
  endtask : push

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #(25 * 5000);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
  end

  // ********
  // Directed sequences
  // ********
  initial
  begin
    repeat (5) tick;
    reset_i = 1'b0;
    rd(A_MASK, 8'h00);
    rd(A_SRC, 8'h01);
    rd(A_LSTAT, 8'h60);
    wr(A_MASK, 8'hff);
    rd(A_MASK, 8'h0f);
    wr(A_LCTL, ENH_KEY);
    for (int i = 4; i < 8; i++)
      wr(3'(i), 8'h30 + 8'(i));
    wr(A_EFC, 8'h10);
    for (int i = 4; i < 8; i++)
      rd(3'(i), 8'h30 + 8'(i));
    rd(A_EFC, 8'h10);
    wr(A_LCTL, 8'h80);
    rd(A_REV, REV_V);
    rd(A_PID, PID_V);
    wr(A_LCTL, 8'h00);
    wr(A_MASK, 8'hf0);
    rd(A_MASK, 8'hf0);
    chk(cfg.mask, 8'hf0);
    wr(A_MASK, 8'h00);
    // Enabling transmit ready with the holding register empty fires at once
    wr(A_MASK, 8'h02);
    chk({7'h0, irq_o}, 8'h01);
    rd(A_SRC, 8'h02);
    rd(A_SRC, 8'h01);
    // FIFO mode, trigger of eight, receive and line interrupts on
    wr(A_FCTL, 8'h01);
    wr(A_MASK, 8'h05);
    push(3'h0, 7);
    rd(A_SRC, 8'hc1);
    push(3'h0, 1);
    rd(A_SRC, 8'hc4);
    rd(A_LSTAT, 8'h61);
    // Overrun waits behind the receive level until that drops below trigger
    ovr = 1'b1;
    tick;
    ovr = 1'b0;
    rd(A_SRC, 8'hc4);
    rd(A_DATA, 8'h88);
    rd(A_SRC, 8'hc6);
    rd(A_LSTAT, 8'h63);
    rd(A_SRC, 8'hc1);
    // Receive timeout, cleared by the next data read
    tmo = 1'b1;
    tick;
    tmo = 1'b0;
    rd(A_SRC, 8'hcc);
    for (int k = 7; k > 0; k--)
      rd(A_DATA, 8'h80 | 8'(k));
    rd(A_LSTAT, 8'h60);
    // Parity error on the only character held
    push(3'h1, 1);
    rd(A_SRC, 8'hc6);
    rd(A_LSTAT, 8'he5);
    rd(A_DATA, 8'h81);
    rd(A_LSTAT, 8'h60);
    wr(A_MASK, 8'h08);
    modem_stat_i = 8'h01;
    tick;
    rd(A_SRC, 8'hc0);
    rd(A_MSTAT, 8'h01);
    modem_stat_i = 8'h00;
    rd(A_SRC, 8'hc1);
    // Pin rises: CTS through the synchroniser, then RTS
    wr(A_MASK, 8'hc0);
    cts_n_pin_i = 1'b0;
    repeat (4) tick;
    cts_n_pin_i = 1'b1;
    repeat (4) tick;
    rd(A_SRC, 8'he0);
    rd(A_MSTAT, 8'h00);
    rd(A_SRC, 8'hc1);
    rts_n_i = 1'b0;
    tick;
    rts_n_i = 1'b1;
    tick;
    rd(A_SRC, 8'he0);
    rd(A_MSTAT, 8'h00);
    // Polled mode: data waits with no interrupt line
    wr(A_MASK, 8'h00);
    push(3'h0, 8);
    chk({7'h0, irq_o}, 8'h00);
    rd(A_LSTAT, 8'h61);
    close_out;
  end
endmodule : uie_core_tb_top
`default_nettype wire
